// [core/vreto_core.sv]
// Raw blanking-line capture and encoder timing packet output
`timescale 1ns/1ps
module vreto_core #(
    parameter logic [vreto_pkg::PHASE_W-1:0] SAMPLE_INC =
        vreto_pkg::SAMPLE_INC_DEFAULT
) (
    input  wire logic                          SYS_CLK_I,
    input  wire logic                          RST_I,
    // Configuration
    input  wire logic [1:0]                    STD_I,
    input  wire logic                          RAW_EN_I,
    input  wire logic                          ALL_LINES_CAPTURE_I,
    input  wire logic [vreto_pkg::MASK_W-1:0]  LINE_MASK_I,
    input  wire logic                          RAW_TIMING_WR_I,
    input  wire logic [7:0]                    RAW_START_I,
    input  wire logic [7:0]                    RAW_STOP_MSB_I,
    input  wire logic [7:0]                    RAW_STOP_LSB_I,
    input  wire logic                          SAMPLE_INC_WR_I,
    input  wire logic [vreto_pkg::PHASE_W-1:0] SAMPLE_INC_I,
    input  wire logic                          PKT_EN_I,
    input  wire logic                          PAL_ENCODE_I,
    // Video timing and samples
    input  wire logic                          LINE_START_I,
    input  wire logic [vreto_pkg::LINE_W-1:0]  LINE_NUM_I,
    input  wire logic                          VBLANK_I,
    input  wire logic [vreto_pkg::HCNT_W-1:0]  SAV_POS_I,
    input  wire logic [7:0]                    VIDEO_I,
    input  wire logic [7:0]                    BLANK_LEVEL_I,
    input  wire logic                          V_POSITIVE_I,
    input  wire logic [31:0]                   SUBCARRIER_INC_I,
    // Outputs
    output logic                               SAMPLE_EN_O,
    output logic [7:0]                         PIXEL_O,
    output logic                               PIXEL_VALID_O,
    output logic                               RAW_ACTIVE_O,
    output logic                               PKT_ACTIVE_O,
    output logic [7:0]                         RAW_START_O,
    output logic [15:0]                        RAW_STOP_O
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [vreto_pkg::PHASE_W-1:0] phase_q;
    logic [vreto_pkg::PHASE_W-1:0] inc_q;
    logic                          sample_en_q;
    logic [vreto_pkg::PHASE_W:0]   phase_sum;

    logic [7:0]                    raw_start_q;
    logic [7:0]                    raw_stop_msb_q;
    logic [7:0]                    raw_stop_lsb_q;
    logic [vreto_pkg::HCNT_W-1:0]  raw_stop;

    logic [vreto_pkg::HCNT_W-1:0]  hcnt_q;
    logic                          line_pend_q;

    logic [vreto_pkg::LINE_W-1:0]  first_line;
    logic [vreto_pkg::LINE_W-1:0]  mask_idx;
    logic                          line_blanked;
    logic                          line_selected;
    logic                          in_window;
    logic                          raw_take;
    logic [7:0]                    raw_val;

    vreto_pkg::vreto_pkt_state_e   state_q;
    logic [4:0]                    idx_q;
    logic [6:0]                    csum_q;
    logic [31:0]                   sub_inc_q;
    logic                          vsign_q;
    logic                          pkt_fits;
    logic [5:0]                    payload;
    logic [7:0]                    anc_word;
    logic [7:0]                    pkt_byte;
    logic [4:0]                    nib_sel;

    ////////////////////////////////////////////////////////////////////////
    // Sample clock enable: phase accumulator on the system clock, since
    // 27 MHz is not an integer division of 200 MHz; jitter is one cycle
    always_comb
    begin
        phase_sum = {1'b0, phase_q} + {1'b0, inc_q};
    end

    always_ff @(posedge SYS_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            inc_q <= SAMPLE_INC;
        end
        else if (SAMPLE_INC_WR_I)
        begin
            inc_q <= SAMPLE_INC_I;
        end
    end

    always_ff @(posedge SYS_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            phase_q     <= '0;
            sample_en_q <= 1'b0;
        end
        else
        begin
            phase_q     <= phase_sum[vreto_pkg::PHASE_W-1:0];
            sample_en_q <= phase_sum[vreto_pkg::PHASE_W];
        end
    end

    assign SAMPLE_EN_O = sample_en_q;

    ////////////////////////////////////////////////////////////////////////
    // Raw capture window registers
    always_ff @(posedge SYS_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            raw_start_q    <= vreto_pkg::RAW_START_DEFAULT;
            raw_stop_msb_q <= vreto_pkg::RAW_STOP_MSB_DEF;
            raw_stop_lsb_q <= vreto_pkg::RAW_STOP_LSB_DEF;
        end
        else if (RAW_TIMING_WR_I)
        begin
            raw_start_q    <= RAW_START_I;
            raw_stop_msb_q <= RAW_STOP_MSB_I;
            raw_stop_lsb_q <= RAW_STOP_LSB_I;
        end
    end

    assign RAW_START_O = raw_start_q;
    assign RAW_STOP_O  = {raw_stop_msb_q, raw_stop_lsb_q};
    assign raw_stop    = vreto_pkg::HCNT_W'({raw_stop_msb_q, raw_stop_lsb_q});

    ////////////////////////////////////////////////////////////////////////
    // Horizontal sample counter, restarted at each line start
    always_ff @(posedge SYS_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            hcnt_q      <= '0;
            line_pend_q <= 1'b0;
        end
        else if (LINE_START_I)
        begin
            hcnt_q      <= '0;
            line_pend_q <= 1'b1;
        end
        else if (sample_en_q)
        begin
            line_pend_q <= 1'b0;
            if (!line_pend_q && hcnt_q != '1)
            begin
                hcnt_q <= hcnt_q + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Line eligibility
    always_comb
    begin
        line_blanked = vreto_pkg::always_blanked(STD_I, LINE_NUM_I);
        unique case (STD_I)
            vreto_pkg::STD_PAL:
                first_line = (LINE_NUM_I >= vreto_pkg::PAL_F2_BEG) ?
                             vreto_pkg::PAL_FIRST2 : vreto_pkg::PAL_FIRST1;
            vreto_pkg::STD_PALM:
                first_line = (LINE_NUM_I >= vreto_pkg::PALM_F2_BEG) ?
                             vreto_pkg::PALM_FIRST2 : vreto_pkg::PALM_FIRST1;
            default:
                first_line = (LINE_NUM_I >= vreto_pkg::NTSC_F2_BEG) ?
                             vreto_pkg::NTSC_FIRST2 : vreto_pkg::NTSC_FIRST1;
        endcase
        mask_idx = LINE_NUM_I - first_line;
        if (ALL_LINES_CAPTURE_I)
        begin
            line_selected = !line_blanked;
        end
        else
        begin
            line_selected = VBLANK_I && !line_blanked &&
                            LINE_MASK_I[mask_idx[4:0]] &&
                            mask_idx < vreto_pkg::LINE_W'(vreto_pkg::MASK_W);
        end
    end

    // Window is independent of the active-video blank timing
    assign in_window = (hcnt_q >= vreto_pkg::HCNT_W'(raw_start_q)) &&
                       (hcnt_q < raw_stop);

    // Sliced data is not consulted, so both can appear on one line
    assign raw_take = RAW_EN_I && line_selected && in_window &&
                      !line_pend_q && state_q == vreto_pkg::VRETO_IDLE;

    // Below blanking clamps to zero rather than wrapping
    assign raw_val = (VIDEO_I > BLANK_LEVEL_I) ?
                     VIDEO_I - BLANK_LEVEL_I : 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Timing packet sequencer: starts at the first sample of the line,
    // skipped when the packet cannot end before start of active video
    assign pkt_fits = SAV_POS_I >= vreto_pkg::HCNT_W'(vreto_pkg::PKT_LEN);

    always_ff @(posedge SYS_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            state_q <= vreto_pkg::VRETO_IDLE;
            idx_q   <= '0;
        end
        else if (sample_en_q)
        begin
            unique case (state_q)
                vreto_pkg::VRETO_IDLE:
                    if (line_pend_q && PKT_EN_I && pkt_fits)
                    begin
                        state_q <= vreto_pkg::VRETO_SEND;
                        idx_q   <= 5'h01;
                    end
                vreto_pkg::VRETO_SEND:
                    if (idx_q == vreto_pkg::IDX_CSUM)
                    begin
                        state_q <= vreto_pkg::VRETO_IDLE;
                        idx_q   <= '0;
                    end
                    else
                    begin
                        idx_q <= idx_q + 1'b1;
                    end
            endcase
        end
    end

    // Timing values frozen at packet start so a line sees one value
    always_ff @(posedge SYS_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            sub_inc_q <= '0;
            vsign_q   <= 1'b0;
        end
        else if (sample_en_q && state_q == vreto_pkg::VRETO_IDLE &&
                 line_pend_q)
        begin
            sub_inc_q <= SUBCARRIER_INC_I;
            vsign_q   <= PAL_ENCODE_I && V_POSITIVE_I;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Packet word content
    always_comb
    begin
        nib_sel = vreto_pkg::IDX_LASTDAT - idx_q;
        payload = 6'h00;
        if (idx_q == vreto_pkg::IDX_DID)
        begin
            payload = vreto_pkg::DID_CODE;
        end
        else if (idx_q == vreto_pkg::IDX_DBN)
        begin
            payload = vreto_pkg::DBN_CODE;
        end
        else if (idx_q == vreto_pkg::IDX_DC)
        begin
            payload = vreto_pkg::DC_CODE;
        end
        else if (idx_q >= vreto_pkg::IDX_SUB0 &&
                 idx_q <= vreto_pkg::IDX_LASTDAT)
        begin
            payload[3:0] = sub_inc_q[{nib_sel[2:0], 2'b00} +: 4];
            payload[5]   = (idx_q == vreto_pkg::IDX_SUB0) ? vsign_q : 1'b0;
        end
    end

    vreto_anc_word u_anc_word (
        .payload_i (payload),
        .word_o    (anc_word)
    );

    always_comb
    begin
        if (idx_q == '0)
        begin
            pkt_byte = vreto_pkg::PRE_ZERO;
        end
        else if (idx_q < vreto_pkg::IDX_DID)
        begin
            pkt_byte = vreto_pkg::PRE_ONES;
        end
        else if (idx_q == vreto_pkg::IDX_CSUM)
        begin
            pkt_byte = {~csum_q[6], csum_q};
        end
        else
        begin
            pkt_byte = anc_word;
        end
    end

    always_ff @(posedge SYS_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            csum_q <= '0;
        end
        else if (sample_en_q)
        begin
            if (state_q == vreto_pkg::VRETO_IDLE)
            begin
                csum_q <= '0;
            end
            else if (idx_q >= vreto_pkg::IDX_DID &&
                     idx_q <= vreto_pkg::IDX_LASTDAT)
            begin
                csum_q <= csum_q + anc_word[6:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pixel output register
    always_ff @(posedge SYS_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            PIXEL_O       <= 8'h00;
            PIXEL_VALID_O <= 1'b0;
            RAW_ACTIVE_O  <= 1'b0;
            PKT_ACTIVE_O  <= 1'b0;
        end
        else if (sample_en_q)
        begin
            PKT_ACTIVE_O  <= 1'b0;
            RAW_ACTIVE_O  <= 1'b0;
            PIXEL_VALID_O <= 1'b0;
            PIXEL_O       <= 8'h00;
            if (state_q == vreto_pkg::VRETO_IDLE && line_pend_q &&
                PKT_EN_I && pkt_fits)
            begin
                PIXEL_O       <= vreto_pkg::PRE_ZERO;
                PIXEL_VALID_O <= 1'b1;
                PKT_ACTIVE_O  <= 1'b1;
            end
            else if (state_q == vreto_pkg::VRETO_SEND)
            begin
                PIXEL_O       <= pkt_byte;
                PIXEL_VALID_O <= 1'b1;
                PKT_ACTIVE_O  <= 1'b1;
            end
            else if (raw_take)
            begin
                PIXEL_O       <= raw_val;
                PIXEL_VALID_O <= 1'b1;
                RAW_ACTIVE_O  <= 1'b1;
            end
        end
        else
        begin
            PIXEL_VALID_O <= 1'b0;
        end
    end

endmodule // vreto_core

// [shared/vreto_pkg.sv]
// Constants and helpers for raw blanking capture and encoder timing packets
// Summary of operation
// - Capture selected blanked lines at sample rate
// - Capture only lines set in mask
// - All-lines bit captures all but equalization lines
// - Start and stop counts bound sampling
// - Subtract blanking level from each sample
// - Sliced and raw output may share lines
// - NTSC eligible from lines 10 and 272
// - NTSC lines 1-9, 264-271 always blanked
// - PAL BDGHIN eligible from lines 6, 318
// - PAL lines 623-5, 311-317 always blanked
// - PAL M eligible from lines 7, 269
// - PAL M lines 523-6, 261-268 always blanked
// - Timing packet once per line before SAV
// - Preamble 00 FF FF, then ID, block, count
// - V-sign zero for NTSC, V sign for PAL
// - Checksum sums P8-P14, carries dropped
// - P14 is even parity over P8-P13
// - Packet carries encoder timing information
// - Start count 7Ah, stop count 034Ah at reset
// - Sample clock defaults to 27 MHz
package vreto_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Clocking
    localparam longint SYS_CLK_HZ       = 200_000_000;
    localparam longint SAMPLE_RATE_HZ   = 27_000_000;
    localparam int     PHASE_W          = 32;
    localparam logic [PHASE_W-1:0] SAMPLE_INC_DEFAULT =
        PHASE_W'((SAMPLE_RATE_HZ << PHASE_W) / SYS_CLK_HZ);

    ////////////////////////////////////////////////////////////////////////
    // Video standards
    localparam logic [1:0] STD_NTSC = 2'h0;
    localparam logic [1:0] STD_PAL  = 2'h1;
    localparam logic [1:0] STD_PALM = 2'h2;

    localparam int LINE_W = 10;
    localparam int HCNT_W = 11;
    localparam int MASK_W = 19;

    // Per standard: first always-blanked line at frame end (PAL and PAL M only), last always-blanked line of
    // field one, first line of field two blanking, first eligible lines
    localparam logic [LINE_W-1:0] NTSC_BLK1_END = 10'h009;
    localparam logic [LINE_W-1:0] NTSC_F2_BEG   = 10'h108;
    localparam logic [LINE_W-1:0] NTSC_FIRST1   = 10'h00A;
    localparam logic [LINE_W-1:0] NTSC_FIRST2   = 10'h110;
    localparam logic [LINE_W-1:0] PAL_BLK0_BEG  = 10'h26F;
    localparam logic [LINE_W-1:0] PAL_BLK1_END  = 10'h005;
    localparam logic [LINE_W-1:0] PAL_F2_BEG    = 10'h137;
    localparam logic [LINE_W-1:0] PAL_FIRST1    = 10'h006;
    localparam logic [LINE_W-1:0] PAL_FIRST2    = 10'h13E;
    localparam logic [LINE_W-1:0] PALM_BLK0_BEG = 10'h20B;
    localparam logic [LINE_W-1:0] PALM_BLK1_END = 10'h006;
    localparam logic [LINE_W-1:0] PALM_F2_BEG   = 10'h105;
    localparam logic [LINE_W-1:0] PALM_FIRST1   = 10'h007;
    localparam logic [LINE_W-1:0] PALM_FIRST2   = 10'h10D;

    ////////////////////////////////////////////////////////////////////////
    // Raw capture window defaults
    localparam logic [7:0]        RAW_START_DEFAULT = 8'h7A;
    localparam logic [7:0]        RAW_STOP_MSB_DEF  = 8'h03;
    localparam logic [7:0]        RAW_STOP_LSB_DEF  = 8'h4A;

    ////////////////////////////////////////////////////////////////////////
    // Timing packet layout
    localparam logic [4:0] PKT_LEN      = 5'h13;
    localparam logic [4:0] IDX_DID      = 5'h03;
    localparam logic [4:0] IDX_DBN      = 5'h04;
    localparam logic [4:0] IDX_DC       = 5'h05;
    localparam logic [4:0] IDX_LINE0    = 5'h06;
    localparam logic [4:0] IDX_SUB0     = 5'h0A;
    localparam logic [4:0] IDX_SUB1     = 5'h0B;
    localparam logic [4:0] IDX_LASTDAT  = 5'h11;
    localparam logic [4:0] IDX_CSUM     = 5'h12;
    localparam logic [7:0] PRE_ZERO     = 8'h00;
    localparam logic [7:0] PRE_ONES     = 8'hFF;
    localparam logic [5:0] DID_CODE     = 6'h35;
    localparam logic [5:0] DBN_CODE     = 6'h01;
    localparam logic [5:0] DC_CODE      = 6'h03;

    typedef enum logic [1:0] {
        VRETO_IDLE = 2'b01,
        VRETO_SEND = 2'b10
    } vreto_pkt_state_e;

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic even_parity(input logic [5:0] bits);
        even_parity = ^bits;
    endfunction

    function automatic logic always_blanked(input logic [1:0]        std,
                                            input logic [LINE_W-1:0] ln);
        logic r;
        r = 1'b0;
        unique case (std)
            STD_PAL:  r = (ln >= PAL_BLK0_BEG) || (ln <= PAL_BLK1_END) ||
                          (ln >= PAL_F2_BEG && ln < PAL_FIRST2);
            STD_PALM: r = (ln >= PALM_BLK0_BEG) || (ln <= PALM_BLK1_END) ||
                          (ln >= PALM_F2_BEG && ln < PALM_FIRST2);
            default:  r = (ln <= NTSC_BLK1_END) ||
                          (ln >= NTSC_F2_BEG && ln < NTSC_FIRST2);
        endcase
        always_blanked = r;
    endfunction

endpackage

// [core/vreto_anc_word.sv]
// Ancillary data word builder: parity and inverted parity on top
`timescale 1ns/1ps
module vreto_anc_word (
    input  wire logic [5:0] payload_i,
    output logic      [7:0] word_o
);

    logic ep;

    always_comb
    begin
        ep     = vreto_pkg::even_parity(payload_i);
        word_o = {~ep, ep, payload_i};
    end

endmodule // vreto_anc_word

// [verification/vreto_asserts.sv]
// Concurrent checks on the pixel port of the capture and packet block
`timescale 1ns/1ps
module vreto_asserts (
    input  wire logic       SYS_CLK_I,
    input  wire logic       RST_I,
    input  wire logic       RAW_EN_I,
    input  wire logic [7:0] VIDEO_I,
    input  wire logic [7:0] BLANK_LEVEL_I,
    input  wire logic       SAMPLE_EN_O,
    input  wire logic [7:0] PIXEL_O,
    input  wire logic       PIXEL_VALID_O,
    input  wire logic       RAW_ACTIVE_O,
    input  wire logic       PKT_ACTIVE_O
);
    // Fixed leading bytes: preamble, header words, zero line increments
    localparam logic [7:0] HDR [10] = '{8'h00, 8'hFF, 8'hFF, 8'hB5, 8'h41,
        8'h83, 8'h80, 8'h80, 8'h80, 8'h80};
    logic [4:0] cnt_q;
    logic [6:0] sum_q;
    logic       pv;

    assign pv = PIXEL_VALID_O && PKT_ACTIVE_O;

    // Byte index inside the packet; restarts whenever the packet ends
    always_ff @(posedge SYS_CLK_I or posedge RST_I)
    begin
        if (RST_I || !PKT_ACTIVE_O)
        begin
            cnt_q <= 5'h00;
            sum_q <= 7'h00;
        end
        else if (PIXEL_VALID_O)
        begin
            cnt_q <= cnt_q + 5'h01;
            if (cnt_q >= 5'h03 && cnt_q <= 5'h11)
            begin
                sum_q <= sum_q + PIXEL_O[6:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (RST_I);

    property p_valid_cause;
        PIXEL_VALID_O |-> $past(SAMPLE_EN_O);
    endproperty
    a_valid_cause: assert property (p_valid_cause)
        else $error("Pixel valid without a sample enable");
    property p_en_spacing;
        SAMPLE_EN_O |=> (!SAMPLE_EN_O)[*6] ##[1:2] SAMPLE_EN_O;
    endproperty
    a_en_spacing: assert property (p_en_spacing)
        else $error("Sample enable spacing not 7 or 8 clocks");
    property p_raw_en;
        PIXEL_VALID_O && RAW_ACTIVE_O |-> $past(RAW_EN_I);
    endproperty
    a_raw_en: assert property (p_raw_en)
        else $error("Raw byte while raw capture disabled");
    property p_raw_sub;
        PIXEL_VALID_O && RAW_ACTIVE_O |-> PIXEL_O ==
            (($past(VIDEO_I) > $past(BLANK_LEVEL_I)) ?
             $past(VIDEO_I) - $past(BLANK_LEVEL_I) : 8'h00);
    endproperty
    a_raw_sub: assert property (p_raw_sub)
        else $error("Raw byte not sample minus blanking level");
    property p_excl;
        !(RAW_ACTIVE_O && PKT_ACTIVE_O);
    endproperty
    a_excl: assert property (p_excl)
        else $error("Raw and packet sources active together");
    property p_hdr;
        pv && cnt_q < 5'h0A |-> PIXEL_O == HDR[cnt_q];
    endproperty
    a_hdr: assert property (p_hdr)
        else $error("Packet header byte wrong");
    property p_parity;
        pv && cnt_q >= 5'h03 && cnt_q <= 5'h11 |-> PIXEL_O[6] == ^PIXEL_O[5:0];
    endproperty
    a_parity: assert property (p_parity)
        else $error("Packet word parity wrong");
    property p_top_bit;
        pv && cnt_q >= 5'h03 |-> PIXEL_O[7] != PIXEL_O[6];
    endproperty
    a_top_bit: assert property (p_top_bit)
        else $error("Packet top bit not inverse of parity bit");
    property p_csum;
        pv && cnt_q == 5'h12 |-> PIXEL_O[6:0] == sum_q;
    endproperty
    a_csum: assert property (p_csum)
        else $error("Packet checksum wrong");
    property p_len;
        $fell(PKT_ACTIVE_O) |-> cnt_q == 5'h13;
    endproperty
    a_len: assert property (p_len)
        else $error("Packet length not 19 bytes");

    c_pkt: cover property ($fell(PKT_ACTIVE_O));
    c_raw: cover property (PIXEL_VALID_O && RAW_ACTIVE_O);
    c_clamp: cover property (PIXEL_VALID_O && RAW_ACTIVE_O && ~|PIXEL_O);
endmodule // vreto_asserts

bind vreto_core vreto_asserts u_asserts (
    .SYS_CLK_I     (SYS_CLK_I),
    .RST_I         (RST_I),
    .RAW_EN_I      (RAW_EN_I),
    .VIDEO_I       (VIDEO_I),
    .BLANK_LEVEL_I (BLANK_LEVEL_I),
    .SAMPLE_EN_O   (SAMPLE_EN_O),
    .PIXEL_O       (PIXEL_O),
    .PIXEL_VALID_O (PIXEL_VALID_O),
    .RAW_ACTIVE_O  (RAW_ACTIVE_O),
    .PKT_ACTIVE_O  (PKT_ACTIVE_O)
);

// [verification/vreto_sink.sv]
// Downstream capture model: gathers packet bytes and counts raw bytes
`timescale 1ns/1ps
module vreto_sink (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       clr_i,
    input  wire logic       valid_i,
    input  wire logic [7:0] pixel_i,
    input  wire logic       raw_i,
    input  wire logic       pkt_i
);
    logic [7:0] pkt_q[$];
    int         raw_n;
    logic [7:0] raw_last;

    // Bytes taken only in the valid cycle; the byte lingers after
    always @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i || clr_i)
        begin
            pkt_q.delete();
            raw_n = 0;
        end
        else if (valid_i && pkt_i)
        begin
            pkt_q.push_back(pixel_i);
        end
        else if (valid_i && raw_i)
        begin
            raw_n++;
            raw_last = pixel_i;
        end
    end
endmodule // vreto_sink

// [verification/test_vbi_raw_and_encoder_timing_output.sv]
// Self-checking bench for raw capture and encoder timing packets
`timescale 1ns/1ps
`define CHK(a, e) \
    begin \
        n_tests++; \
        if ((a) !== (e)) \
        begin \
            mismatches++; \
            $display("Error at %0t: got %h exp %h", $time, a, e); \
        end \
    end
module test_vbi_raw_and_encoder_timing_output;
    logic clk = 0, rst = 1, raw_en = 0, all_cap = 0, twr = 0, pkt_en = 0;
    logic pal_enc = 0, lstart = 0, vblank = 0, vpos = 0, clr = 0;
    logic [1:0]  std = 2'h0;
    logic [18:0] mask = 19'h00000;
    logic [7:0]  rstart = 8'h00, rsmsb = 8'h00, rslsb = 8'h00;
    logic [7:0]  video = 8'h00, blank = 8'h00, pix, ro_start;
    logic [9:0]  lnum = 10'h000;
    logic [10:0] sav = 11'h200;
    logic [31:0] sub = 32'h9E3B5A17;
    logic [15:0] ro_stop;
    logic        sen, pval, ract, pact;
    int          mismatches = 0, n_tests = 0;

    always #2.5 clk = ~clk;

    vreto_core dut (.SYS_CLK_I(clk), .RST_I(rst), .STD_I(std),
        .RAW_EN_I(raw_en), .ALL_LINES_CAPTURE_I(all_cap), .LINE_MASK_I(mask),
        .RAW_TIMING_WR_I(twr), .RAW_START_I(rstart), .RAW_STOP_MSB_I(rsmsb),
        .RAW_STOP_LSB_I(rslsb), .SAMPLE_INC_WR_I(1'b0),
        .SAMPLE_INC_I(32'h00000000), .PKT_EN_I(pkt_en),
        .PAL_ENCODE_I(pal_enc), .LINE_START_I(lstart), .LINE_NUM_I(lnum),
        .VBLANK_I(vblank), .SAV_POS_I(sav), .VIDEO_I(video),
        .BLANK_LEVEL_I(blank), .V_POSITIVE_I(vpos),
        .SUBCARRIER_INC_I(sub), .SAMPLE_EN_O(sen), .PIXEL_O(pix),
        .PIXEL_VALID_O(pval), .RAW_ACTIVE_O(ract), .PKT_ACTIVE_O(pact),
        .RAW_START_O(ro_start), .RAW_STOP_O(ro_stop));
    vreto_sink u_sink (.clk_i(clk), .rst_i(rst), .clr_i(clr), .valid_i(pval),
        .pixel_i(pix), .raw_i(ract), .pkt_i(pact));

    ////////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // One line: start pulse, then 40 sample enables with a bounded wait
    task automatic run_line(input logic [1:0] s, input logic [9:0] ln);
        int k;
        std = s;
        lnum = ln;
        {clr, lstart} = 2'b11;
        @(negedge clk);
        {clr, lstart} = 2'b00;
        repeat (40)
        begin
            k = 0;
            do
            begin
                @(negedge clk);
                k++;
            end
            while (sen !== 1'b1 && k < 20);
            if (k >= 20)
                `CHK(sen, 1'b1)
        end
        repeat (3) @(negedge clk);
    endtask

    task automatic sel(input logic [1:0] s, input logic [9:0] ln,
                       input logic a, input logic [18:0] m, input int x);
        all_cap = a;
        mask = m;
        run_line(s, ln);
        `CHK(u_sink.raw_n, x)
        $display("Test line %0d std %0d done", ln, s);
    endtask

    function automatic logic [7:0] wd(input logic [5:0] p);
        return {~^p, ^p, p};
    endfunction

    task automatic pkt_check(input logic vs);
        logic [7:0] e [19];
        logic [6:0] c;
        e[0] = 8'h00;
        e[1] = 8'hFF;
        e[2] = 8'hFF;
        e[3] = wd(6'h35);
        e[4] = wd(6'h01);
        e[5] = wd(6'h03);
        for (int i = 6; i < 10; i++)
            e[i] = wd(6'h00);
        for (int i = 0; i < 8; i++)
            e[10+i] = wd({(i == 0) & vs, 1'b0, sub[31-4*i -: 4]});
        c = 7'h00;
        for (int i = 3; i < 18; i++)
            c += e[i][6:0];
        e[18] = {~c[6], c};
        `CHK(u_sink.pkt_q.size(), 19)
        for (int i = 0; i < 19; i++)
            `CHK(u_sink.pkt_q[i], e[i])
        $display("Test packet vsign %0b done", vs);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20) @(negedge clk);
        rst = 0;
        `CHK(ro_start, 8'h7A)
        `CHK(ro_stop, 16'h034A)
        // Short window keeps each line a few hundred clocks long
        {rstart, rsmsb, rslsb, twr} = {8'h18, 8'h00, 8'h1C, 1'b1};
        @(negedge clk);
        twr = 0;
        @(negedge clk);
        `CHK(ro_start, 8'h18)
        `CHK(ro_stop, 16'h001C)
        {raw_en, all_cap, video, blank} = {1'b1, 1'b1, 8'h90, 8'h10};
        run_line(2'h0, 10'h064);
        `CHK(u_sink.raw_n, 4)
        `CHK(u_sink.raw_last, 8'h80)
        video = 8'h05;
        run_line(2'h0, 10'h064);
        `CHK(u_sink.raw_last, 8'h00)
        $display("Test raw window done");
        vblank = 1;
        sel(2'h0, 10'h009, 1, 19'h00000, 0);
        sel(2'h0, 10'h00A, 0, 19'h00001, 4);
        sel(2'h0, 10'h00B, 0, 19'h00001, 0);
        sel(2'h0, 10'h00B, 0, 19'h00002, 4);
        sel(2'h0, 10'h10F, 1, 19'h00000, 0);
        sel(2'h0, 10'h110, 0, 19'h00001, 4);
        sel(2'h1, 10'h005, 1, 19'h00000, 0);
        sel(2'h1, 10'h26F, 1, 19'h00000, 0);
        sel(2'h1, 10'h006, 0, 19'h00001, 4);
        sel(2'h1, 10'h13D, 1, 19'h00000, 0);
        sel(2'h1, 10'h13E, 0, 19'h00001, 4);
        sel(2'h2, 10'h006, 1, 19'h00000, 0);
        sel(2'h2, 10'h20B, 1, 19'h00000, 0);
        sel(2'h2, 10'h007, 0, 19'h00001, 4);
        sel(2'h2, 10'h10C, 1, 19'h00000, 0);
        sel(2'h2, 10'h10D, 0, 19'h00001, 4);
        // Packet and raw on one line; smallest accepted SAV position
        {vblank, all_cap, pkt_en, pal_enc, vpos, sav} =
            {1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 11'h013};
        run_line(2'h1, 10'h064);
        pkt_check(1'b1);
        `CHK(u_sink.raw_n, 4)
        pal_enc = 0;
        sub = 32'h61C4A5F0;
        run_line(2'h0, 10'h064);
        pkt_check(1'b0);
        sav = 11'h012;
        run_line(2'h0, 10'h064);
        `CHK(u_sink.pkt_q.size(), 0)
        {sav, pkt_en, raw_en} = {11'h200, 1'b0, 1'b0};
        run_line(2'h0, 10'h064);
        `CHK(u_sink.pkt_q.size(), 0)
        `CHK(u_sink.raw_n, 0)
        $display("Test packet refusal done");
        complete_run;
    end

    // Some 22 lines of 300 clocks each
    initial
    begin
        #200000;
        mismatches++;
        $display("Error at %0t: watchdog expired", $time);
        complete_run;
    end
endmodule // test_vbi_raw_and_encoder_timing_output
